// File: design/mtc_timer.sv
// Multifunction 16-bit timer core with Avalon-MM register slave.
// Assumes a synchronous Avalon master on clk_sys; pins are asynchronous.
// Notes on behaviour
// RULE1: 16-bit up/down counter stepped through an 8-bit prescaler.
// RULE2: Prescaler fed by internal clock divided by three or external clock.
// RULE3: Two compare registers and two capture/load/reload registers.
// RULE4: Each input detects rising, falling or both edges as configured.
// RULE5: Each output driven by compare zero, compare one or end of count.
// RULE6: Each source applies nop, set, reset or toggle per output.
// RULE7: On-chip event pulses on end of count and compare zero.
// RULE8: Five masked sources form three prioritised requests with vectors.
// RULE9: DMA requests for capture zero and compare zero preempt interrupts.
// RULE10: Triggers come from soft flags or configured edges, capture or load.
// RULE11: Input A or soft trigger zero acts on register zero, unless bi-capture.
// RULE12: Input B or soft trigger one acts on register one.
// RULE13: With load zero and monitor one, input B may trigger register zero.
// RULE14: One-shot stops the counter at end of count without reload.
// RULE15: Stopped one-shot restarts on A, B or soft trigger zero only.
// RULE16: Continuous select bit set means one-shot, clear means continuous.
// RULE17: Continuous end of count reloads from register zero or bi-load one; wraps when register zero captures.
// RULE18: One-shot ignores triggers while running, or reloads when retriggerable.
// RULE19: Edges and soft flags are synchronised and acted on once.
`timescale 1ns/1ps
`include "mtc_defs.svh"
module mtc_timer
   import mtc_pkg::*;
(
   input wire logic clk_sys, // System clock
   input wire logic resetn, // Async reset
   input wire logic [7:0] avs_address, // Byte address
   input wire logic avs_read, // Read request
   input wire logic avs_write, // Write request
   input wire logic [31:0] avs_writedata, // Write data
   input wire logic [3:0] avs_byteenable, // Byte lanes
   output logic [31:0] avs_readdata, // Read data
   output logic avs_waitrequest, // Stall
   input wire logic input_a_pin, // External input A
   input wire logic input_b_pin, // External input B
   input wire logic ext_clk_pin, // External count clock
   output logic [1:0] out_pin, // Timer outputs
   output logic on_chip_event, // Event pulse
   output logic irq, // Any enabled status
   output logic [2:0] irq_req, // Compare, capture, end of count
   output logic [1:0] irq_vector, // Highest pending request
   output logic [1:0] dma_req, // Compare zero, capture zero
   input wire logic [1:0] dma_ack // DMA acknowledge
);
   logic req;
   logic wr_en;
   logic [31:0] bmask;
   logic [31:0] rdata;
   logic ctrl_en_q;
   logic ctrl_up_q;
   mtc_mode_s mode_q;
   mtc_icr_s icr_q;
   mtc_outc_s [1:0] outc_q;
   logic [7:0] presc_q;
   logic [7:0] pcnt_q;
   logic [1:0] div3_q;
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic [15:0] cl_q [2];
   logic [15:0] cmp_q [2];
   logic [4:0] status_q;
   logic [4:0] ien_q;
   logic [4:0] ev;
   logic [4:0] pend;
   logic [1:0] dmaen_q;
   logic [1:0] st_q;
   logic bl_sel_q;
   logic bc_sel_q;
   mtc_run_e run_st_q;
   logic [2:0] pins;
   logic [2:0] sync1_q;
   logic [2:0] sync2_q;
   logic [2:0] prev_q;
   logic [1:0] edge_hit;
   logic [1:0] esel [2];
   logic [1:0] cmp_hit;
   logic src_tick;
   logic step;
   logic counting;
   logic step_cnt;
   logic one_shot;
   logic at_end;
   logic eoc;
   logic a_trig;
   logic b_trig;
   logic b_for_zero;
   logic trig0;
   logic trig1;
   logic bicap;
   logic free_run;
   logic restart;
   logic load0;
   logic load1;
   logic cap0;
   logic cap1;
   logic monitor;
   logic sw_start;
   logic sw_stop;

   function automatic logic hit(input logic [7:0] off);
      return wr_en && (avs_address == off);
   endfunction

   function automatic logic [15:0] w16(input logic [15:0] old);
      return (old & ~bmask[15:0]) | (avs_writedata[15:0] & bmask[15:0]);
   endfunction

   function automatic logic act(input logic v, input mtc_act_e a);
      case (a)
         mtc_set: return 1'b1;
         mtc_clr: return 1'b0;
         mtc_tgl: return ~v;
         default: return v;
      endcase
   endfunction

   // One wait state: the answer comes one edge after the request
   assign req = avs_read | avs_write;
   assign wr_en = avs_write & ~avs_waitrequest;
   assign bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                   {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= ~(req & avs_waitrequest);
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         avs_readdata <= '0;
      end else if (avs_read && avs_waitrequest) begin
         avs_readdata <= rdata;
      end
   end

   always_comb begin
      rdata = '0;
      case (avs_address)
         `MTC_OFF_CTRL: begin
            rdata[`MTC_CTRL_EN] = ctrl_en_q;
            rdata[`MTC_CTRL_UP] = ctrl_up_q;
            rdata[`MTC_CTRL_RUNNING] = (run_st_q == mtc_run);
         end
         `MTC_OFF_MODE: rdata = 32'(mode_q);
         `MTC_OFF_PRESC: rdata = 32'(presc_q);
         `MTC_OFF_ICR: rdata = 32'(icr_q);
         `MTC_OFF_CNT: rdata = 32'(cnt_q);
         `MTC_OFF_CL0: rdata = 32'(cl_q[0]);
         `MTC_OFF_CL1: rdata = 32'(cl_q[1]);
         `MTC_OFF_CMP0: rdata = 32'(cmp_q[0]);
         `MTC_OFF_CMP1: rdata = 32'(cmp_q[1]);
         `MTC_OFF_OUTC: rdata = 32'(outc_q);
         `MTC_OFF_ISTAT: rdata = 32'(status_q);
         `MTC_OFF_IEN: rdata = 32'(ien_q);
         `MTC_OFF_DMAEN: rdata = 32'(dmaen_q);
         default: rdata = '0;
      endcase
   end

   // RULE3 RULE16 configuration registers
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ctrl_en_q <= 1'b0;
         ctrl_up_q <= 1'b0;
         mode_q <= '0;
         icr_q <= '0;
         outc_q <= '0;
         presc_q <= `MTC_RST_PRESC;
         cmp_q[0] <= `MTC_RST_W16;
         cmp_q[1] <= `MTC_RST_W16;
         ien_q <= '0;
         dmaen_q <= '0;
      end else begin
         if (hit(`MTC_OFF_CTRL) && avs_byteenable[0]) begin
            ctrl_en_q <= avs_writedata[`MTC_CTRL_EN];
            ctrl_up_q <= avs_writedata[`MTC_CTRL_UP];
         end
         if (hit(`MTC_OFF_MODE)) mode_q <= `MTC_MODE_W'(w16(16'(mode_q)));
         if (hit(`MTC_OFF_ICR)) icr_q <= `MTC_ICR_W'(w16(16'(icr_q)));
         if (hit(`MTC_OFF_OUTC)) outc_q <= `MTC_OUTC_W'(w16(16'(outc_q)));
         if (hit(`MTC_OFF_PRESC)) presc_q <= 8'(w16(16'(presc_q)));
         if (hit(`MTC_OFF_CMP0)) cmp_q[0] <= w16(cmp_q[0]);
         if (hit(`MTC_OFF_CMP1)) cmp_q[1] <= w16(cmp_q[1]);
         if (hit(`MTC_OFF_IEN)) ien_q <= `MTC_NSRC'(w16(16'(ien_q)));
         if (hit(`MTC_OFF_DMAEN)) dmaen_q <= 2'(w16(16'(dmaen_q)));
      end
   end

   // RULE19 soft flags live one cycle so each write acts once
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         st_q <= '0;
      end else begin
         st_q <= hit(`MTC_OFF_FLAGS) ? (avs_writedata[1:0] & bmask[1:0]) : 2'b00;
      end
   end

   // RULE19 two-stage synchronisers, edge taken from the second stage
   assign pins = {ext_clk_pin, input_b_pin, input_a_pin};
   assign esel[0] = icr_q.input_a_edge_select;
   assign esel[1] = icr_q.input_b_edge_select;
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_sync
         always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
               sync1_q[gi] <= 1'b0;
               sync2_q[gi] <= 1'b0;
               prev_q[gi] <= 1'b0;
            end else begin
               sync1_q[gi] <= pins[gi];
               sync2_q[gi] <= sync1_q[gi];
               prev_q[gi] <= sync2_q[gi];
            end
         end
      end
      for (gi = 0; gi < 2; gi++) begin : g_edge
         // RULE4 edge select per input
         assign edge_hit[gi] = (esel[gi][0] & sync2_q[gi] & ~prev_q[gi]) |
                               (esel[gi][1] & ~sync2_q[gi] & prev_q[gi]);
      end
   endgenerate

   // RULE2 clock source select
   assign src_tick = mode_q.ext_clk ? (sync2_q[2] & ~prev_q[2]) : (div3_q == `MTC_DIV3_LAST);
   // RULE1 prescaler divides by its value plus one
   assign step = src_tick & (pcnt_q == presc_q);

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         div3_q <= `MTC_DIV3_ZERO;
         pcnt_q <= `MTC_RST_PRESC;
      end else begin
         div3_q <= (div3_q == `MTC_DIV3_LAST) ? `MTC_DIV3_ZERO : div3_q + 1'b1;
         if (src_tick) pcnt_q <= step ? `MTC_RST_PRESC : pcnt_q + 1'b1;
      end
   end

   // RULE16 continuous select bit picks one-shot
   assign one_shot = mode_q.continuous_select_bit;
   assign counting = ctrl_en_q & (run_st_q == mtc_run);
   assign step_cnt = step & counting;
   assign at_end = ctrl_up_q ? (cnt_q == `MTC_CNT_MAX) : (cnt_q == `MTC_CNT_MIN);
   assign eoc = step_cnt & at_end;
   assign bicap = mode_q.bivalue & mode_q.reg0_capture;
   assign free_run = mode_q.reg0_capture & ~one_shot;
   assign monitor = ~mode_q.reg1_capture & ~mode_q.bivalue;

   // RULE10 trigger sources
   assign a_trig = edge_hit[0] & icr_q.a_en;
   assign b_trig = edge_hit[1] & icr_q.b_en;
   // RULE13 input B may serve register zero
   assign b_for_zero = mode_q.b_to_zero & ~mode_q.reg0_capture & monitor;
   // RULE11 register zero trigger
   assign trig0 = a_trig | st_q[0] | (b_trig & b_for_zero);
   // RULE12 register one trigger
   assign trig1 = (b_trig & ~b_for_zero) | st_q[1];

   // RULE15 soft trigger one cannot restart
   assign restart = one_shot & ctrl_en_q & (run_st_q == mtc_stop) &
                    (a_trig | st_q[0] | b_trig);
   // RULE18 retrigger only when enabled
   assign load0 = ~mode_q.reg0_capture &
                  (restart | (trig0 & counting & (~one_shot | mode_q.retrig)));
   assign load1 = trig1 & ~one_shot & counting & mode_q.bivalue &
                  ~mode_q.reg0_capture & ~mode_q.reg1_capture;
   // RULE11 bi-capture alternates register zero and one
   assign cap0 = trig0 & mode_q.reg0_capture & ~(bicap & bc_sel_q);
   assign cap1 = (trig0 & bicap & bc_sel_q) | (trig1 & mode_q.reg1_capture & ~bicap);

   assign sw_start = hit(`MTC_OFF_CTRL) & avs_byteenable[0] & avs_writedata[`MTC_CTRL_EN];
   assign sw_stop = hit(`MTC_OFF_CTRL) & avs_byteenable[0] & ~avs_writedata[`MTC_CTRL_EN];

   // RULE14 one-shot stops at end of count
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         run_st_q <= mtc_stop;
      end else begin
         case (run_st_q)
            mtc_stop: if (sw_start || restart) run_st_q <= mtc_run;
            mtc_run: if (sw_stop || (eoc && one_shot)) run_st_q <= mtc_stop;
            default: run_st_q <= mtc_stop;
         endcase
      end
   end

   always_comb begin
      cnt_d = cnt_q;
      if (load0) begin
         cnt_d = cl_q[0];
      end else if (load1) begin
         cnt_d = cl_q[1];
      end else if (eoc && one_shot) begin
         cnt_d = cnt_q;
      end else if (eoc && !free_run) begin
         // RULE17 continuous reload, alternating in bi-load
         cnt_d = (mode_q.bivalue && bl_sel_q) ? cl_q[1] : cl_q[0];
      end else if (step_cnt) begin
         // RULE1 up or down step, wrapping when free running
         cnt_d = ctrl_up_q ? cnt_q + `MTC_CNT_ONE : cnt_q - `MTC_CNT_ONE;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= `MTC_RST_W16;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // Low bivalue resets both alternations to register zero
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         bl_sel_q <= 1'b0;
         bc_sel_q <= 1'b0;
      end else begin
         if (!mode_q.bivalue || load0) bl_sel_q <= load0 & mode_q.bivalue;
         else if (eoc && !free_run && !one_shot) bl_sel_q <= ~bl_sel_q;
         if (!bicap) bc_sel_q <= 1'b0;
         else if (trig0) bc_sel_q <= ~bc_sel_q;
      end
   end

   // RULE3 capture wins over a software write in the same cycle
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cl_q[0] <= `MTC_RST_W16;
         cl_q[1] <= `MTC_RST_W16;
      end else begin
         if (cap0) cl_q[0] <= cnt_q;
         else if (hit(`MTC_OFF_CL0)) cl_q[0] <= w16(cl_q[0]);
         if (cap1) cl_q[1] <= cnt_q;
         else if (monitor) cl_q[1] <= cnt_d;
         else if (hit(`MTC_OFF_CL1)) cl_q[1] <= w16(cl_q[1]);
      end
   end

   assign cmp_hit[0] = step_cnt & (cnt_d == cmp_q[0]);
   assign cmp_hit[1] = step_cnt & (cnt_d == cmp_q[1]);

   // RULE9 DMA-enabled sources bypass their status bit
   always_comb begin
      ev = '0;
      ev[`MTC_ST_EOC] = eoc;
      ev[`MTC_ST_CAP0] = cap0 & ~dmaen_q[0];
      ev[`MTC_ST_CAP1] = cap1;
      ev[`MTC_ST_CMP0] = cmp_hit[0] & ~dmaen_q[1];
      ev[`MTC_ST_CMP1] = cmp_hit[1];
   end

   // New events win over a clear in the same cycle
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         status_q <= '0;
      end else begin
         status_q <= (status_q & ~(hit(`MTC_OFF_ICLR) ? `MTC_NSRC'(w16('0)) : '0)) | ev;
      end
   end

   // RULE9 request held until acknowledged, new event wins
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         dma_req <= '0;
      end else begin
         dma_req[0] <= (dma_req[0] & ~dma_ack[0]) | (cap0 & dmaen_q[0]);
         dma_req[1] <= (dma_req[1] & ~dma_ack[1]) | (cmp_hit[0] & dmaen_q[1]);
      end
   end

   // RULE8 end of count outranks capture, capture outranks compare
   assign pend = status_q & ien_q;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         irq <= 1'b0;
         irq_req <= '0;
         irq_vector <= `MTC_VEC_NONE;
      end else begin
         irq <= |pend;
         irq_req <= {|pend[`MTC_ST_CMP1:`MTC_ST_CMP0], |pend[`MTC_ST_CAP1:`MTC_ST_CAP0],
                     pend[`MTC_ST_EOC]};
         if (pend[`MTC_ST_EOC]) irq_vector <= `MTC_VEC_EOC;
         else if (|pend[`MTC_ST_CAP1:`MTC_ST_CAP0]) irq_vector <= `MTC_VEC_CAP;
         else if (|pend[`MTC_ST_CMP1:`MTC_ST_CMP0]) irq_vector <= `MTC_VEC_CMP;
         else irq_vector <= `MTC_VEC_NONE;
      end
   end

   // RULE7 on-chip event
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         on_chip_event <= 1'b0;
      end else begin
         on_chip_event <= eoc | cmp_hit[0];
      end
   end

   generate
      for (gi = 0; gi < 2; gi++) begin : g_out
         logic v0;
         logic v1;
         // RULE5 RULE6 sources applied in order compare zero, one, end of count
         assign v0 = cmp_hit[0] ? act(out_pin[gi], outc_q[gi].cmp0) : out_pin[gi];
         assign v1 = cmp_hit[1] ? act(v0, outc_q[gi].cmp1) : v0;
         always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
               out_pin[gi] <= 1'b0;
            end else begin
               out_pin[gi] <= eoc ? act(v1, outc_q[gi].ovf) : v1;
            end
         end
      end
   endgenerate

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);

   bus_wait_a: assert property (req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("waitrequest not one cycle low");
   os_stop_a: assert property (eoc && one_shot |=> // RULE14
      run_st_q == mtc_stop && cnt_q == $past(cnt_q))
      else $error("one-shot did not stop");
   cont_reload_a: assert property (eoc && !one_shot && !free_run && !mode_q.bivalue // RULE17
      && !load0 && !load1 |=> cnt_q == $past(cl_q[0]))
      else $error("continuous reload wrong");
   no_restart_a: assert property (one_shot && run_st_q == mtc_stop && st_q[1] // RULE15
      && !st_q[0] && !a_trig && !b_trig && !sw_start |=> run_st_q == mtc_stop)
      else $error("soft trigger one restarted");
   restart_a: assert property (restart && !mode_q.reg0_capture |=> // RULE15
      run_st_q == mtc_run && cnt_q == $past(cl_q[0]))
      else $error("restart failed");
   trig_mask_a: assert property (one_shot && counting && !mode_q.retrig && trig0 // RULE18
      && !step_cnt && !sw_stop |=> cnt_q == $past(cnt_q))
      else $error("trigger not masked");
   retrig_a: assert property (one_shot && counting && mode_q.retrig && trig0 // RULE18
      && !mode_q.reg0_capture |=> cnt_q == $past(cl_q[0]))
      else $error("retrigger did not reload");
   irq_eoc_a: assert property (eoc && ien_q[`MTC_ST_EOC] |=> // RULE8
      (ien_q[`MTC_ST_EOC] |-> ##1 irq && irq_vector == `MTC_VEC_EOC && irq_req[0]))
      else $error("end of count interrupt missing");
   dma_first_a: assert property (cap0 && dmaen_q[0] && !status_q[`MTC_ST_CAP0] // RULE9
      && !hit(`MTC_OFF_DMAEN) |=> dma_req[0] && !status_q[`MTC_ST_CAP0])
      else $error("DMA did not preempt interrupt");
   cap_zero_a: assert property (cap0 |=> cl_q[0] == $past(cnt_q)) // RULE11
      else $error("capture zero lost");
   out_tgl_a: assert property (eoc && !cmp_hit[0] && !cmp_hit[1] && // RULE6
      outc_q[0].ovf == mtc_tgl |=> out_pin[0] != $past(out_pin[0]))
      else $error("output toggle missing");
   evt_a: assert property (cmp_hit[0] |=> on_chip_event) // RULE7
      else $error("on-chip event missing");

   os_end_c: cover property (eoc && one_shot ##[1:20] restart);
   bicap_c: cover property (cap1 && bicap);
   dma_c: cover property (dma_req[0] && dma_ack[0]);
   biload_c: cover property (eoc && mode_q.bivalue && bl_sel_q);
endmodule

// File: design/mtc_defs.svh
// Register offsets, field positions, reset values and counts of the timer core.
// Included by the package and by the core; definitions only.
`ifndef MTC_DEFS_SVH
`define MTC_DEFS_SVH
`define MTC_OFF_CTRL 8'h00
`define MTC_OFF_MODE 8'h04
`define MTC_OFF_PRESC 8'h08
`define MTC_OFF_ICR 8'h0c
`define MTC_OFF_FLAGS 8'h10
`define MTC_OFF_CNT 8'h14
`define MTC_OFF_CL0 8'h18
`define MTC_OFF_CL1 8'h1c
`define MTC_OFF_CMP0 8'h20
`define MTC_OFF_CMP1 8'h24
`define MTC_OFF_OUTC 8'h28
`define MTC_OFF_ISTAT 8'h2c
`define MTC_OFF_ICLR 8'h30
`define MTC_OFF_IEN 8'h34
`define MTC_OFF_DMAEN 8'h38
`define MTC_CTRL_EN 0
`define MTC_CTRL_UP 1
`define MTC_CTRL_RUNNING 2
`define MTC_MODE_W 7
`define MTC_ICR_W 6
`define MTC_OUTC_W 12
`define MTC_NSRC 5
`define MTC_ST_EOC 0
`define MTC_ST_CAP0 1
`define MTC_ST_CAP1 2
`define MTC_ST_CMP0 3
`define MTC_ST_CMP1 4
`define MTC_VEC_NONE 2'h0
`define MTC_VEC_EOC 2'h1
`define MTC_VEC_CAP 2'h2
`define MTC_VEC_CMP 2'h3
`define MTC_CNT_MAX 16'hffff
`define MTC_CNT_MIN 16'h0000
`define MTC_CNT_ONE 16'h0001
`define MTC_DIV3_LAST 2'h2
`define MTC_DIV3_ZERO 2'h0
`define MTC_RST_W16 16'h0000
`define MTC_RST_PRESC 8'h00
`endif

// File: design/mtc_pkg.sv
// Types of the timer core: output actions, run state, register layouts.
// Assumes mtc_defs.svh on the include path.
`include "mtc_defs.svh"
package mtc_pkg;
   typedef enum logic [1:0] {
      mtc_nop = 2'b00,
      mtc_set = 2'b01,
      mtc_clr = 2'b10,
      mtc_tgl = 2'b11
   } mtc_act_e;
   typedef enum logic {
      mtc_stop = 1'b0,
      mtc_run = 1'b1
   } mtc_run_e;
   typedef struct packed {
      logic b_to_zero;
      logic reg1_capture;
      logic reg0_capture;
      logic retrig;
      logic continuous_select_bit;
      logic bivalue;
      logic ext_clk;
   } mtc_mode_s;
   typedef struct packed {
      logic b_en;
      logic a_en;
      logic [1:0] input_b_edge_select;
      logic [1:0] input_a_edge_select;
   } mtc_icr_s;
   typedef struct packed {
      mtc_act_e ovf;
      mtc_act_e cmp1;
      mtc_act_e cmp0;
   } mtc_outc_s;
endpackage

// File: verification/mtc_pins.sv
// Model of the circuitry at the pins: trigger inputs A and B, external count clock.
// Assumes requests from the bench on clk_sys; pins change just after a rising edge.
`timescale 1ns/1ps
module mtc_pins (
   input wire logic clk_sys, // System clock
   input wire logic [1:0] lvl, // Wanted levels of B and A
   input wire logic ext_run, // Run the count clock
   output logic input_a_pin = 1'b0, // Input A
   output logic input_b_pin = 1'b0, // Input B
   output logic ext_clk_pin = 1'b0 // Count clock
);
   logic [1:0] div_q = 2'h0;
   // Slow source so every edge survives the two-stage sync; still when idle
   always @(posedge clk_sys) begin
      input_a_pin <= lvl[0];
      input_b_pin <= lvl[1];
      div_q <= ext_run ? div_q + 2'h1 : 2'h0;
      ext_clk_pin <= div_q[1];
   end
endmodule

// File: verification/multifunction_timer_core_test.sv
// Self-checking bench of the timer core: bus tasks, pin model, scenarios.
// Assumes the core answers each bus request one cycle after taking it.
`timescale 1ns/1ps
`include "mtc_defs.svh"
module multifunction_timer_core_test;
   import mtc_pkg::*;
   logic clk_sys = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0, ext_run = 1'b0;
   logic [7:0] avs_address = 8'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q, v;
   logic avs_waitrequest, input_a_pin, input_b_pin, ext_clk_pin, on_chip_event, irq;
   logic [1:0] out_pin, irq_vector, dma_req, lvl = 2'h0, dma_ack = 2'h0;
   logic [2:0] irq_req;
   logic [1:0] pin_l [4] = '{2'h0, 2'h2, 2'h0, 2'h1};
   logic [31:0] cap_e [4] = '{32'h0, 32'h0, 32'h4, 32'h2};
   int err_total = 0, n_tests = 0, cyc = 0, ev_n = 0;
   always #5 clk_sys = ~clk_sys;
   mtc_timer u_mtc_timer (.clk_sys(clk_sys), .resetn(resetn), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .input_a_pin(input_a_pin), .input_b_pin(input_b_pin), .ext_clk_pin(ext_clk_pin),
      .out_pin(out_pin), .on_chip_event(on_chip_event), .irq(irq), .irq_req(irq_req),
      .irq_vector(irq_vector), .dma_req(dma_req), .dma_ack(dma_ack));
   mtc_pins u_mtc_pins (.clk_sys(clk_sys), .lvl(lvl), .ext_run(ext_run),
      .input_a_pin(input_a_pin), .input_b_pin(input_b_pin), .ext_clk_pin(ext_clk_pin));
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Holds the request until waitrequest is sampled low, then releases it
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (n >= 20) err_total++;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q & m, e);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   always @(posedge clk_sys) begin
      if (on_chip_event === 1'b1) ev_n++;
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         end_sim();
      end
   end
   initial begin
      v = $urandom(32'hfbbb);
      repeat (5) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      chk({irq, irq_req, irq_vector, dma_req, out_pin, avs_waitrequest}, 32'h1);
      rdc(8'h3c, 32'hffffffff, 32'h0);
      bus(1'b1, `MTC_OFF_MODE, 32'h20);
      for (int i = 0; i < 4; i++) begin
         v = $urandom;
         bus(1'b1, `MTC_OFF_CL0 + 8'(i * 4), v);
         rdc(`MTC_OFF_CL0 + 8'(i * 4), 32'hffffffff, {16'h0, v[15:0]});
      end
      $display("done: register access");
      bus(1'b1, `MTC_OFF_CL0, 32'hfffd);
      bus(1'b1, `MTC_OFF_MODE, 32'h04);
      bus(1'b1, `MTC_OFF_ICR, 32'h11);
      bus(1'b1, `MTC_OFF_CTRL, 32'h3);
      // Running one-shot without retrigger ignores soft trigger zero
      bus(1'b1, `MTC_OFF_FLAGS, 32'h1);
      rdc(`MTC_OFF_CNT, 32'hfff0, 32'h0);
      bus(1'b1, `MTC_OFF_MODE, 32'h0c);
      bus(1'b1, `MTC_OFF_FLAGS, 32'h1);
      wt(60);
      rdc(`MTC_OFF_CNT, 32'hffffffff, 32'hffff);
      rdc(`MTC_OFF_ISTAT, 32'h1, 32'h1);
      bus(1'b1, `MTC_OFF_ICLR, 32'h1f);
      bus(1'b1, `MTC_OFF_FLAGS, 32'h2);
      wt(60);
      rdc(`MTC_OFF_ISTAT, 32'h1, 32'h0);
      lvl <= 2'h1;
      wt(60);
      rdc(`MTC_OFF_ISTAT, 32'h1, 32'h1);
      $display("done: one-shot");
      bus(1'b1, `MTC_OFF_CTRL, 32'h0);
      bus(1'b1, `MTC_OFF_CL0, 32'h5);
      bus(1'b1, `MTC_OFF_MODE, 32'h0);
      bus(1'b1, `MTC_OFF_CTRL, 32'h1);
      // Counter sits at the top; a load starts the short period
      bus(1'b1, `MTC_OFF_FLAGS, 32'h1);
      ev_n = 0;
      wt(100);
      bus(1'b0, `MTC_OFF_CNT, 32'h0);
      chk({31'h0, q <= 32'h5}, 32'h1);
      chk({31'h0, ev_n > 3}, 32'h1);
      bus(1'b1, `MTC_OFF_IEN, 32'h1);
      wt(3);
      chk({irq, irq_vector, irq_req}, {1'b1, `MTC_VEC_EOC, 3'b001});
      bus(1'b1, `MTC_OFF_IEN, 32'h0);
      wt(3);
      chk(irq, 1'b0);
      $display("done: continuous");
      bus(1'b1, `MTC_OFF_CTRL, 32'h0);
      bus(1'b1, `MTC_OFF_MODE, 32'h30);
      bus(1'b1, `MTC_OFF_ICR, 32'h39);
      bus(1'b1, `MTC_OFF_IEN, 32'h6);
      bus(1'b1, `MTC_OFF_CTRL, 32'h3);
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, `MTC_OFF_ICLR, 32'h1f);
         lvl <= pin_l[i];
         wt(10);
         rdc(`MTC_OFF_ISTAT, 32'h6, cap_e[i]);
      end
      chk({irq, irq_vector}, {1'b1, `MTC_VEC_CAP});
      bus(1'b1, `MTC_OFF_ICLR, 32'h1f);
      wt(2);
      chk(irq, 1'b0);
      bus(1'b1, `MTC_OFF_DMAEN, 32'h1);
      lvl <= 2'h0;
      wt(6);
      lvl <= 2'h1;
      wt(10);
      chk(dma_req, 2'b01);
      rdc(`MTC_OFF_ISTAT, 32'h2, 32'h0);
      $display("done: capture");
      bus(1'b1, `MTC_OFF_CTRL, 32'h0);
      bus(1'b1, `MTC_OFF_MODE, 32'h11);
      bus(1'b1, `MTC_OFF_CTRL, 32'h3);
      bus(1'b0, `MTC_OFF_CNT, 32'h0);
      v = q;
      wt(30);
      rdc(`MTC_OFF_CNT, 32'hffffffff, v);
      ext_run <= 1'b1;
      wt(40);
      bus(1'b0, `MTC_OFF_CNT, 32'h0);
      chk({31'h0, q != v}, 32'h1);
      ext_run <= 1'b0;
      $display("done: external clock");
      bus(1'b1, `MTC_OFF_CTRL, 32'h0);
      bus(1'b1, `MTC_OFF_MODE, 32'h0c);
      bus(1'b1, `MTC_OFF_CL0, 32'hfff0);
      bus(1'b1, `MTC_OFF_CMP0, 32'hfff4);
      bus(1'b1, `MTC_OFF_OUTC, 32'h431);
      bus(1'b1, `MTC_OFF_IEN, 32'h8);
      bus(1'b1, `MTC_OFF_DMAEN, 32'h2);
      bus(1'b1, `MTC_OFF_ICLR, 32'h1f);
      bus(1'b1, `MTC_OFF_CTRL, 32'h3);
      // One pass: compare sets out0, end of count toggles it and sets out1
      bus(1'b1, `MTC_OFF_FLAGS, 32'h1);
      wt(120);
      chk(out_pin, 2'b10);
      rdc(`MTC_OFF_ISTAT, 32'h8, 32'h0);
      chk({dma_req, irq}, 3'b110);
      dma_ack <= 2'h3;
      @(posedge clk_sys);
      dma_ack <= 2'h0;
      @(posedge clk_sys);
      chk(dma_req, 2'b00);
      $display("done: outputs and dma");
      end_sim();
   end
endmodule
